// ---- logic/sdram_pin_pkg.sv ----
package sdram_pin_pkg;

  localparam logic [5:0] SDRAM_REGION = 6'h01;
  localparam int REGION_HI = 31;
  localparam int REGION_LO = 26;
  localparam int ADDR_W = 32;
  localparam int ROW_W = 14;
  localparam int BANK_W = 2;

  // Operation codes that the controller core requests.
  typedef enum logic [2:0] {
    OP_NOP, OP_ACTIVATE, OP_READ, OP_WRITE, OP_PRECHARGE, OP_REFRESH, OP_MODE, OP_SELF_REFRESH
  } op_type;

  // Strobe triple {row, column, write}; each bit is active low.
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_MODE = 3'h0;

  // Decodes the strobe triple for a command; used only by the pin interface.
  function automatic logic [2:0] cmd_code(input op_type op);
    unique case (op)
      OP_ACTIVATE: cmd_code = CMD_ACTIVATE;
      OP_READ: cmd_code = CMD_READ;
      OP_WRITE: cmd_code = CMD_WRITE;
      OP_PRECHARGE: cmd_code = CMD_PRECHARGE;
      OP_REFRESH, OP_SELF_REFRESH: cmd_code = CMD_REFRESH;
      OP_MODE: cmd_code = CMD_MODE;
      default: cmd_code = CMD_NOP;
    endcase
  endfunction

endpackage

// ---- logic/sdram_mask_gen.sv ----
`timescale 1ns/100ps
// Works out the two word masks for one column command.
module sdram_mask_gen
  import sdram_pin_pkg::*;
(
  // Command and addressing.
  input wire op_type op,
  input wire logic word_odd,
  input wire logic single_word,
  input wire logic bus_is_32,
  // Masks, active high.
  output logic low_mask,
  output logic high_mask
);

  // Masks only rise on writes; reads and non-column commands keep them low.
  always_comb begin
    low_mask = 1'b0;
    high_mask = 1'b0;
    if (op == OP_WRITE) begin
      low_mask = word_odd && !bus_is_32;
      high_mask = bus_is_32 || (single_word && !word_odd);
    end
  end

endmodule // sdram_mask_gen

// ---- logic/sdram_pin_interface.sv ----
`timescale 1ns/100ps
// Registers the pin-side SDRAM command stream from the controller core.
module sdram_pin_interface
  import sdram_pin_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int RW = ROW_W,
  parameter int BW = BANK_W
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Controller core request.
  input wire logic req_valid,
  input wire op_type req_op,
  input wire logic [AW-1:0] req_addr,
  input wire logic [RW-1:0] req_row,
  input wire logic [RW-1:0] req_col,
  input wire logic [BW-1:0] req_bank,
  input wire logic req_word_odd,
  input wire logic req_single_word,
  input wire logic req_auto_precharge,
  input wire logic req_all_banks,
  output logic req_ready,
  // Configuration and ownership.
  input wire logic bus_is_32,
  input wire logic is_bus_master,
  input wire logic suspend_req,
  // Host arbitration pins, active low.
  input wire logic host_bus_request_n,
  output logic host_bus_grant_n,
  // SDRAM pins; each output enable is low while driving.
  output logic sdram_region_select_n,
  output logic sdram_region_select_oe_n,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic sdram_write_en_n,
  output logic low_word_mask,
  output logic high_word_mask,
  output logic [RW-1:0] sdram_addr,
  output logic [BW-1:0] sdram_bank,
  output logic sdram_addr_bit_ten,
  output logic sdram_clock_en,
  output logic sdram_cmd_oe_n,
  // Status.
  output logic in_self_refresh
);

  initial begin
    if (AW < REGION_HI + 1 || RW < 11 || BW < 1) begin
      $error("sdram_pin_interface: unsupported width parameters");
    end
  end

  typedef enum logic [1:0] {ST_RUN, ST_SUSPEND, ST_SELF_REF, ST_HOST} mode_type;

  typedef struct packed {
    mode_type mode;
    logic [1:0] hbr_sync;
    logic region_sel_n;
    logic [2:0] cmd;
    logic low_mask;
    logic high_mask;
    logic [RW-1:0] addr;
    logic [BW-1:0] bank;
    logic a10;
    logic cke;
    logic float_n;
    logic sel_float_n;
    logic grant_n;
  } state_type;

  state_type state_r;
  state_type state_nxt;
  logic mask_low;
  logic mask_high;
  logic hbr_seen;
  logic take;

  assign hbr_seen = !state_r.hbr_sync[1];

  // The mask generator sees the incoming command directly.
  sdram_mask_gen u_mask (
    .op(req_op),
    .word_odd(req_word_odd),
    .single_word(req_single_word),
    .bus_is_32(bus_is_32),
    .low_mask(mask_low),
    .high_mask(mask_high)
  );

  // Requests are only taken while running and owning the bus.
  assign req_ready = (state_r.mode == ST_RUN) && is_bus_master && !hbr_seen;
  assign take = req_valid && req_ready;

  // Next-state logic for pins and power mode.
  always_comb begin
    state_nxt = state_r;
    state_nxt.hbr_sync = {state_r.hbr_sync[0], host_bus_request_n};
    state_nxt.cmd = CMD_NOP;
    state_nxt.region_sel_n = 1'b1;
    state_nxt.low_mask = 1'b0;
    state_nxt.high_mask = 1'b0;
    unique case (state_r.mode)
      ST_RUN: begin
        state_nxt.cke = 1'b1;
        if (hbr_seen && is_bus_master) begin
          // Park the memory in self-refresh before the host takes over.
          state_nxt.cmd = CMD_REFRESH;
          state_nxt.region_sel_n = 1'b0;
          state_nxt.cke = 1'b0;
          state_nxt.mode = ST_SELF_REF;
        end else if (suspend_req && !req_valid) begin
          state_nxt.cke = 1'b0;
          state_nxt.mode = ST_SUSPEND;
        end else if (take) begin
          state_nxt.region_sel_n =
            !(req_addr[REGION_HI:REGION_LO] == SDRAM_REGION);
          state_nxt.cmd = cmd_code(req_op);
          state_nxt.bank = req_bank;
          unique case (req_op)
            OP_ACTIVATE: begin
              state_nxt.addr = req_row;
              state_nxt.a10 = req_row[10];
            end
            OP_READ, OP_WRITE: begin
              state_nxt.addr = req_col;
              state_nxt.a10 = req_auto_precharge;
              state_nxt.low_mask = mask_low;
              state_nxt.high_mask = mask_high;
            end
            OP_PRECHARGE: begin
              state_nxt.a10 = req_all_banks;
            end
            OP_MODE: begin
              state_nxt.addr = req_row;
              state_nxt.a10 = req_row[10];
            end
            OP_SELF_REFRESH: begin
              state_nxt.cke = 1'b0;
              state_nxt.mode = ST_SELF_REF;
            end
            default: begin
            end
          endcase
        end
      end
      ST_SUSPEND: begin
        if (!suspend_req) begin
          state_nxt.cke = 1'b1;
          state_nxt.mode = ST_RUN;
        end
      end
      ST_SELF_REF: begin
        if (hbr_seen && is_bus_master) begin
          // Memory already parked; release the command and select pins and grant; clock enable stays driven low.
          state_nxt.float_n = 1'b0;
          state_nxt.grant_n = 1'b0;
          state_nxt.mode = ST_HOST;
        end else if (!hbr_seen && !suspend_req) begin
          state_nxt.cke = 1'b1;
          state_nxt.mode = ST_RUN;
        end
      end
      ST_HOST: begin
        // Grant holds until the host drops its request.
        if (!hbr_seen) begin
          state_nxt.grant_n = 1'b1;
          state_nxt.float_n = 1'b1;
          state_nxt.mode = ST_SELF_REF;
        end
      end
    endcase
    // Select floats in the same cycle as the other pins when the host takes over.
    state_nxt.sel_float_n = is_bus_master && (state_nxt.mode != ST_HOST);
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= '{mode: ST_RUN, hbr_sync: 2'h3, region_sel_n: 1'b1, cmd: CMD_NOP,
                   low_mask: 1'b0, high_mask: 1'b0, addr: '0, bank: '0, a10: 1'b0,
                   cke: 1'b1, float_n: 1'b1, sel_float_n: 1'b0, grant_n: 1'b1};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pin drivers; the enables are low while the pins are driven.
  assign sdram_region_select_n = state_r.region_sel_n;
  assign sdram_region_select_oe_n = !state_r.sel_float_n;
  assign {row_strobe_n, column_strobe_n, sdram_write_en_n} = state_r.cmd;
  assign low_word_mask = state_r.low_mask;
  assign high_word_mask = state_r.high_mask;
  assign sdram_addr = state_r.addr;
  assign sdram_bank = state_r.bank;
  assign sdram_addr_bit_ten = state_r.a10;
  assign sdram_clock_en = state_r.cke;
  assign sdram_cmd_oe_n = !state_r.float_n;
  assign host_bus_grant_n = state_r.grant_n;
  assign in_self_refresh = (state_r.mode == ST_SELF_REF) || (state_r.mode == ST_HOST);

endmodule // sdram_pin_interface

// ---- verif/sdram_pin_chk.sv ----
`timescale 1ns/100ps
// Watches the pin side of the SDRAM interface against the core requests.
module sdram_pin_chk
  import sdram_pin_pkg::*;
(
  // Clock, reset and core request.
  input wire logic sys_clk, sys_rst, req_valid, req_ready, req_word_odd, req_single_word,
  input wire logic req_all_banks, bus_is_32, is_bus_master, suspend_req, host_bus_grant_n,
  input wire op_type req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [ROW_W-1:0] req_row, req_col, sdram_addr,
  // SDRAM pins.
  input wire logic sdram_region_select_n, sdram_region_select_oe_n, row_strobe_n,
  input wire logic column_strobe_n, sdram_write_en_n, low_word_mask, high_word_mask,
  input wire logic sdram_addr_bit_ten, sdram_clock_en, sdram_cmd_oe_n, in_self_refresh
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Accepted request and the strobe triple on the pins.
  wire logic tk = req_valid && req_ready;
  wire logic [2:0] cmd = {row_strobe_n, column_strobe_n, sdram_write_en_n};
  property p_sel; tk && req_addr[31:26] == SDRAM_REGION |=> !sdram_region_select_n; endproperty
  a_sel: assert property (p_sel) else $error("select missing");
  property p_mst; !is_bus_master |=> sdram_region_select_oe_n; endproperty
  a_mst: assert property (p_mst) else $error("select driven by slave");
  property p_act; tk && req_op == OP_ACTIVATE |=>
    cmd == CMD_ACTIVATE && sdram_addr == $past(req_row);
  endproperty
  a_act: assert property (p_act) else $error("activate wrong");
  property p_rd; tk && req_op == OP_READ |=> cmd == CMD_READ && sdram_addr == $past(req_col);
  endproperty
  a_rd: assert property (p_rd) else $error("read wrong");
  property p_msk; low_word_mask || high_word_mask |-> cmd == CMD_WRITE; endproperty
  a_msk: assert property (p_msk) else $error("mask outside write");
  property p_lo; tk && req_op == OP_WRITE |=>
    low_word_mask == ($past(req_word_odd) && !$past(bus_is_32));
  endproperty
  a_lo: assert property (p_lo) else $error("low mask wrong");
  property p_hi; tk && req_op == OP_WRITE |=>
    high_word_mask == ($past(bus_is_32) || ($past(req_single_word) && !$past(req_word_odd)));
  endproperty
  a_hi: assert property (p_hi) else $error("high mask wrong");
  property p_a10; tk && req_op == OP_PRECHARGE |=> sdram_addr_bit_ten == $past(req_all_banks);
  endproperty
  a_a10: assert property (p_a10) else $error("bit ten wrong");
  property p_gnt; !host_bus_grant_n |->
    sdram_cmd_oe_n && sdram_region_select_oe_n && in_self_refresh;
  endproperty
  a_gnt: assert property (p_gnt) else $error("pins driven while granted");
  property p_cke;
    !in_self_refresh && !$past(in_self_refresh) && !$past(suspend_req) |-> sdram_clock_en;
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable low");
endmodule // sdram_pin_chk
bind sdram_pin_interface sdram_pin_chk chk_inst (.*);

// ---- verif/sdram_mem_model.sv ----
`timescale 1ns/100ps
// Memory side: drives read data lanes one cycle after a read unless masked.
module sdram_mem_model (
  // Pins from the controller.
  input wire logic sys_clk, column_strobe_n, sdram_write_en_n, sdram_cmd_oe_n,
  input wire logic low_word_mask, high_word_mask,
  // Lane drive enables, low while driving.
  output logic [1:0] lane_drive_n
);
  // A masked lane stays floating.
  always @(posedge sys_clk) begin
    lane_drive_n <= 2'h3;
    if (!sdram_cmd_oe_n && !column_strobe_n && sdram_write_en_n) begin
      lane_drive_n <= {high_word_mask, low_word_mask};
    end
  end
endmodule // sdram_mem_model

// ---- verif/sdram_pin_interface_tb.sv ----
`timescale 1ns/100ps
// Self-checking bench for the SDRAM pin interface.
module sdram_pin_interface_tb;
  import sdram_pin_pkg::*;
  logic sys_clk, sys_rst, req_valid, req_word_odd, req_single_word, req_auto_precharge;
  logic req_all_banks, bus_is_32, is_bus_master, suspend_req, host_bus_request_n, req_ready;
  logic host_bus_grant_n, sdram_region_select_n, sdram_region_select_oe_n, row_strobe_n;
  logic column_strobe_n, sdram_write_en_n, low_word_mask, high_word_mask, sdram_addr_bit_ten;
  logic sdram_clock_en, sdram_cmd_oe_n, in_self_refresh, quiet;
  op_type req_op;
  logic [31:0] req_addr;
  logic [13:0] req_row, req_col, sdram_addr;
  logic [1:0] req_bank, sdram_bank, lane_drive_n;
  logic [5:0] exp_q[$];
  logic [2:0] tbl[8] = '{CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
    CMD_REFRESH, CMD_MODE, CMD_REFRESH};
  int err_total = 0, check_count = 0, i;
  // Pin pattern compared against each note: select, strobe triple, masks.
  wire logic [5:0] pins = {sdram_region_select_n, row_strobe_n, column_strobe_n,
    sdram_write_en_n, low_word_mask, high_word_mask};
  sdram_pin_interface sdram_pin_interface_inst (.*);
  sdram_mem_model sdram_mem_model_inst (.*);
  // Clock generation.
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  task chk(string what, logic [13:0] e, logic [13:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_on(ref logic s, input logic v);
    for (int n = 0; n < 40 && s !== v; n++) @(negedge sys_clk);
    if (s !== v) begin
      err_total++;
      close_out;
    end
  endtask
  // Issues one request and notes the pin pattern it must produce.
  task automatic send(op_type op, logic hit);
    logic o, s, b;
    o = 1'($urandom);
    s = 1'($urandom);
    b = 1'($urandom);
    @(negedge sys_clk);
    wait_on(req_ready, 1'b1);
    @(posedge sys_clk);
    req_valid <= 1;
    req_op <= op;
    req_addr <= {hit ? 6'h01 : 6'h02, 26'($urandom)};
    {req_row, req_col, req_bank, req_all_banks} <= 31'($urandom);
    {req_word_odd, req_single_word, bus_is_32} <= {o, s, b};
    if (op != OP_NOP) exp_q.push_back({!hit, tbl[op], op == OP_WRITE && o && !b,
      op == OP_WRITE && (b || (s && !o))});
    @(posedge sys_clk);
    req_valid <= 0;
  endtask
  // Compares each command seen on the pins, except while quiet is set, with the oldest note.
  always @(negedge sys_clk) begin
    if (!sys_rst && !quiet && {row_strobe_n, column_strobe_n, sdram_write_en_n} !== CMD_NOP) begin
      if (exp_q.size() == 0) chk("spare command", 14'h0, 14'h1);
      else chk("pins", 14'(exp_q.pop_front()), 14'(pins));
    end
  end
  // Main sequence.
  initial begin
    {sys_rst, is_bus_master, host_bus_request_n, quiet, req_valid, suspend_req} = 6'h38;
    {req_auto_precharge, req_word_odd, req_single_word, bus_is_32, req_all_banks} = 5'h00;
    {req_addr, req_row, req_col, req_bank} = 62'h0;
    req_op = OP_NOP;
    void'($urandom(92581));
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    @(negedge sys_clk);
    chk("reset select", 14'h1, 14'(sdram_region_select_n));
    for (i = 0; i < 60; i++) send(op_type'(i < 7 ? i : $urandom_range(6)), 1'($urandom));
    // Self-refresh entry by command; the block falls back to running on its own.
    send(OP_SELF_REFRESH, 1);
    send(OP_READ, 1);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("lanes", 14'h0, 14'(lane_drive_n));
    $display("commands done");
    // Suspend drops the clock enable and refuses requests until released.
    @(posedge sys_clk);
    suspend_req <= 1;
    repeat (3) @(negedge sys_clk);
    chk("suspend pins", 14'h0, 14'({sdram_clock_en, req_ready}));
    @(posedge sys_clk);
    suspend_req <= 0;
    repeat (3) @(negedge sys_clk);
    chk("resume pins", 14'h3, 14'({sdram_clock_en, req_ready}));
    $display("suspend done");
    @(posedge sys_clk);
    is_bus_master <= 0;
    repeat (3) @(negedge sys_clk);
    chk("slave select oe", 14'h3, 14'({sdram_region_select_oe_n, !req_ready}));
    @(posedge sys_clk);
    is_bus_master <= 1;
    quiet <= 1;
    host_bus_request_n <= 0;
    wait_on(host_bus_grant_n, 1'b0);
    chk("granted pins", 14'h6, 14'({sdram_region_select_oe_n, sdram_cmd_oe_n,
      sdram_clock_en}));
    @(posedge sys_clk);
    host_bus_request_n <= 1;
    wait_on(host_bus_grant_n, 1'b1);
    wait_on(sdram_clock_en, 1'b1);
    repeat (3) @(negedge sys_clk);
    chk("run pins", 14'h1, 14'({sdram_cmd_oe_n, sdram_clock_en}));
    quiet <= 0;
    send(OP_WRITE, 1);
    repeat (3) @(negedge sys_clk);
    $display("host done");
    close_out;
  end
endmodule // sdram_pin_interface_tb
